// ### slpck_ctrl.sv
// Sleep-mode controller: clock gating, wake decision and wake delays
//
// What this block does
// - Idle stops only the CPU clock and the memories.
// - Idle also halts flash and EEPROM.
// - Idle keeps DMA and event system clocked.
// - Any enabled interrupt wakes from idle.
// - Power-down gates all domains and oscillators.
// - Power-down wakes only on external events.
// - Power-save keeps RTC; RTC interrupts wake.
// - Power-save wake waits for oscillator stabilization.
// - Standby is power-down with system oscillator running.
// - Extended standby is power-save plus system oscillator.
// - Port and two-wire interrupts wake every mode.
// - Battery variant keeps RTC running always.
// - Mode change applies at next sleep entry.
// - Prescaler ratio changes without glitches.
// - Wake latency depends on system clock source.
// - RC or external clock: six-cycle start-up.
// - Thirteen cycles before interrupt routine starts.
`timescale 1ns/10ps
module slpck_ctrl
	import slpck_pkg::*;
#(
	parameter logic [15:0] P_QUARTZ_CYC = SLPCK_QUARTZ_CYC
)
(
	input  wire logic                   i_clock,
	input  wire logic                   i_srst,
	input  wire logic                   i_ce,
	input  wire logic                   i_sleep_en,
	input  wire slpck_mode_e            i_sleep_mode,
	input  wire logic                   i_sleep_instr,
	input  wire slpck_wake_s            i_wake,
	input  wire slpck_src_e             i_clk_src,
	input  wire logic                   i_xtal_ceramic,
	input  wire logic                   i_batt_rtc,
	input  wire logic [SLPCK_PSC_W-1:0] i_prescale,
	output slpck_gate_s                 o_gate,
	output logic                        o_cpu_tick,
	output logic                        o_per_tick,
	output logic                        o_asleep,
	output logic                        o_cpu_run,
	output logic                        o_isr_go,
	output slpck_mode_e                 o_mode
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		slpck_state_e state;
		slpck_mode_e  mode;
		slpck_gate_s  gate;
		logic         isr_go;
	} slpck_ctl_s;

	slpck_ctl_s             st_r;
	slpck_ctl_s             st_nxt;
	logic                   dly_load;
	logic [SLPCK_CNT_W-1:0] dly_count;
	logic                   dly_busy;
	logic                   dly_done;
	logic                   psc_tick;
	logic                   wake_ok;
	logic                   osc_restart;
	logic [SLPCK_CNT_W-1:0] start_cyc;

	////////////////////////////////////////////////////////////////////////
	// Enables held while asleep in a given mode
	function automatic slpck_gate_s gate_for(slpck_mode_e m, logic batt);
		slpck_gate_s g;
		g = '0;
		case (m)
			SLPCK_IDLE: begin
				g = SLPCK_GATE_ALL;
				g.cpu_clk = 1'b0;
				g.nvm     = 1'b0;
				g.dma_evsys = 1'b1;
			end
			SLPCK_PDOWN: begin
				g = '0;
			end
			SLPCK_PSAVE: begin
				g.rtc_clk = 1'b1;
				g.rtc_osc = 1'b1;
			end
			SLPCK_STBY: begin
				g.sys_osc = 1'b1;
			end
			SLPCK_ESTBY: begin
				g.rtc_clk = 1'b1;
				g.rtc_osc = 1'b1;
				g.sys_osc = 1'b1;
			end
			default: begin
				g = SLPCK_GATE_ALL;
				g.cpu_clk = 1'b0;
				g.nvm     = 1'b0;
			end
		endcase
		// Battery-backed RTC never stops, even in power-down
		if (batt) begin
			g.rtc_clk = 1'b1;
			g.rtc_osc = 1'b1;
		end
		return g;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Wake qualification for the latched mode
	always_comb begin
		wake_ok = i_wake.port_async || i_wake.two_wire_serial;
		case (st_r.mode)
			SLPCK_IDLE: begin
				wake_ok = wake_ok || i_wake.any_irq || i_wake.rtc;
			end
			SLPCK_PSAVE,
			SLPCK_ESTBY: begin
				wake_ok = wake_ok || i_wake.rtc;
			end
			default: begin
				wake_ok = wake_ok;
			end
		endcase
	end

	// Modes that stop the system oscillator must let it settle first
	assign osc_restart = (st_r.mode == SLPCK_PDOWN) ||
	                     (st_r.mode == SLPCK_PSAVE);

	// Start-up count follows the selected source; a fast source wakes
	// sooner, which is why software may switch before sleeping
	always_comb begin
		case (i_clk_src)
			SLPCK_SRC_RC,
			SLPCK_SRC_EXT: begin
				start_cyc = SLPCK_RC_START_CYC;
			end
			SLPCK_SRC_XTAL: begin
				start_cyc = i_xtal_ceramic ? SLPCK_CERAMIC_CYC
				                           : P_QUARTZ_CYC;
			end
			default: begin
				start_cyc = SLPCK_RC_START_CYC;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep sequence
	always_comb begin
		st_nxt        = st_r;
		st_nxt.isr_go = 1'b0;
		dly_load      = 1'b0;
		dly_count     = SLPCK_ISR_MIN_CYC;
		case (st_r.state)
			SLPCK_ST_ACTIVE: begin
				st_nxt.gate = SLPCK_GATE_ALL;
				if (i_sleep_en && i_sleep_instr) begin
					// Mode sampled here only, so a change made while
					// awake takes effect at the next entry
					st_nxt.state = SLPCK_ST_SLEEP;
					st_nxt.mode  = i_sleep_mode;
					st_nxt.gate  = gate_for(i_sleep_mode, i_batt_rtc);
				end
			end
			SLPCK_ST_SLEEP: begin
				if (wake_ok) begin
					dly_load = 1'b1;
					if (osc_restart) begin
						st_nxt.state = SLPCK_ST_OSC_WAIT;
						dly_count    = start_cyc;
						st_nxt.gate.sys_osc = 1'b1;
					end else begin
						st_nxt.state = SLPCK_ST_ISR_WAIT;
						st_nxt.gate  = SLPCK_GATE_ALL;
					end
				end
			end
			SLPCK_ST_OSC_WAIT: begin
				// CPU held until the oscillator has settled
				if (dly_done) begin
					st_nxt.state = SLPCK_ST_ISR_WAIT;
					st_nxt.gate  = SLPCK_GATE_ALL;
					dly_load     = 1'b1;
					dly_count    = SLPCK_ISR_MIN_CYC;
				end
			end
			SLPCK_ST_ISR_WAIT: begin
				// Return address push and vector jump
				if (dly_done) begin
					st_nxt.state  = SLPCK_ST_ACTIVE;
					st_nxt.isr_go = 1'b1;
				end
			end
			default: begin
				st_nxt.state = SLPCK_ST_ACTIVE;
				st_nxt.gate  = SLPCK_GATE_ALL;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			st_r <= '{state: SLPCK_ST_ACTIVE, mode: SLPCK_IDLE,
			          gate: SLPCK_GATE_ALL, isr_go: 1'b0};
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Submodules
	slpck_delay u_delay (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_ce    (i_ce),
		.i_load  (dly_load),
		.i_count (dly_count),
		.o_busy  (dly_busy),
		.o_done  (dly_done)
	);

	slpck_prescaler u_psc (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_ce    (i_ce),
		.i_ratio (i_prescale),
		.o_tick  (psc_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs; ticks are gated by domain enable, never a clock itself
	assign o_gate     = st_r.gate;
	assign o_cpu_tick = psc_tick && st_r.gate.cpu_clk;
	assign o_per_tick = psc_tick && st_r.gate.per_clk;
	assign o_asleep   = (st_r.state == SLPCK_ST_SLEEP);
	assign o_cpu_run  = (st_r.state == SLPCK_ST_ACTIVE) ||
	                    (st_r.state == SLPCK_ST_ISR_WAIT);
	assign o_isr_go   = st_r.isr_go;
	assign o_mode     = st_r.mode;

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic [SLPCK_CNT_W-1:0] chk_osc_cnt;
	logic [SLPCK_CNT_W-1:0] chk_isr_cnt;

	// Cycles spent in each wait state, for latency checks
	always_ff @(posedge i_clock) begin
		if (i_srst || st_r.state != SLPCK_ST_OSC_WAIT) begin
			chk_osc_cnt <= '0;
		end else if (i_ce) begin
			chk_osc_cnt <= chk_osc_cnt + 1'b1;
		end
		if (i_srst || st_r.state != SLPCK_ST_ISR_WAIT) begin
			chk_isr_cnt <= '0;
		end else if (i_ce) begin
			chk_isr_cnt <= chk_isr_cnt + 1'b1;
		end
	end

	AST_IDLE_GATES: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_IDLE) |-> (!o_gate.cpu_clk &&
		o_gate.per_clk && o_gate.rtc_clk && o_gate.sys_osc && o_gate.rtc_osc))
		else $error("Idle sleep gating wrong");

	AST_IDLE_NVM: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_IDLE) |-> !o_gate.nvm)
		else $error("Memories not halted in idle");

	AST_IDLE_DMA: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_IDLE) |-> o_gate.dma_evsys)
		else $error("DMA and events stopped in idle");

	AST_IDLE_WAKE: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_IDLE && i_wake.any_irq && i_ce)
		|=> (o_cpu_run && !o_asleep))
		else $error("Interrupt failed to wake idle");

	AST_PDOWN_GATES: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_PDOWN && !i_batt_rtc) |->
		(o_gate == '0))
		else $error("Power-down left something running");

	AST_PDOWN_HOLD: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_PDOWN && !i_wake.port_async &&
		!i_wake.two_wire_serial) |=> o_asleep)
		else $error("Power-down woke on internal event");

	AST_PSAVE_GATES: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_PSAVE) |-> (o_gate.rtc_clk &&
		o_gate.rtc_osc && !o_gate.cpu_clk && !o_gate.per_clk &&
		!o_gate.sys_osc))
		else $error("Power-save gating wrong");

	AST_RC_START: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_PSAVE && i_wake.rtc && i_ce &&
		i_clk_src == SLPCK_SRC_RC) |=> (!o_cpu_run [*6]) ##1 o_cpu_run)
		else $error("Oscillator start-up delay not six cycles");

	AST_OSC_HOLD: assert property (@(posedge i_clock) disable iff (i_srst)
		(st_r.state == SLPCK_ST_OSC_WAIT) |-> (!o_cpu_run && o_gate.sys_osc))
		else $error("CPU ran before oscillator settled");

	AST_OSC_LEN: assert property (@(posedge i_clock) disable iff (i_srst)
		(st_r.state == SLPCK_ST_OSC_WAIT && dly_done) |->
		(dly_busy && chk_osc_cnt + 16'h0001 == start_cyc))
		else $error("Start-up delay length wrong");

	AST_STBY_GATES: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_STBY && !i_batt_rtc) |->
		(o_gate.sys_osc && !o_gate.per_clk && !o_gate.rtc_clk))
		else $error("Standby gating wrong");

	AST_ESTBY_GATES: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && o_mode == SLPCK_ESTBY) |-> (o_gate.sys_osc &&
		o_gate.rtc_clk && o_gate.rtc_osc && !o_gate.per_clk))
		else $error("Extended standby gating wrong");

	AST_EXT_WAKE: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && i_ce && (i_wake.port_async || i_wake.two_wire_serial))
		|=> !o_asleep)
		else $error("External event did not wake");

	AST_BATT_RTC: assert property (@(posedge i_clock) disable iff (i_srst)
		i_batt_rtc && o_asleep |-> (o_gate.rtc_clk && o_gate.rtc_osc))
		else $error("Battery RTC stopped in sleep");

	AST_MODE_LATCH: assert property (@(posedge i_clock) disable iff (i_srst)
		(o_asleep && $past(o_asleep)) |-> $stable(o_mode))
		else $error("Mode changed during sleep");

	AST_ISR_DELAY: assert property (@(posedge i_clock) disable iff (i_srst)
		o_isr_go |-> ($past(chk_isr_cnt) == 16'h000C))
		else $error("Interrupt routine started early");

	AST_ENTRY: assert property (@(posedge i_clock) disable iff (i_srst)
		(!o_asleep ##1 o_asleep) |-> $past(i_sleep_en && i_sleep_instr))
		else $error("Sleep entered without request");

endmodule // slpck_ctrl

// ### slpck_pkg.sv
// Package: sleep-mode clock gating types, fields and cycle counts
package slpck_pkg;

	////////////////////////////////////////////////////////////////////////
	// Sleep modes; idle is the lightest, power-down the deepest
	typedef enum logic [2:0] {
		SLPCK_IDLE,
		SLPCK_PDOWN,
		SLPCK_PSAVE,
		SLPCK_STBY,
		SLPCK_ESTBY
	} slpck_mode_e;

	// Controller sequence
	typedef enum logic [1:0] {
		SLPCK_ST_ACTIVE,
		SLPCK_ST_SLEEP,
		SLPCK_ST_OSC_WAIT,
		SLPCK_ST_ISR_WAIT
	} slpck_state_e;

	// System clock source selection
	typedef enum logic [1:0] {
		SLPCK_SRC_RC,
		SLPCK_SRC_EXT,
		SLPCK_SRC_XTAL
	} slpck_src_e;

	////////////////////////////////////////////////////////////////////////
	// Clock domain and oscillator enables
	typedef struct packed {
		logic cpu_clk;
		logic per_clk;
		logic rtc_clk;
		logic sys_osc;
		logic rtc_osc;
		logic nvm;
		logic dma_evsys;
	} slpck_gate_s;

	// Wake event inputs
	typedef struct packed {
		logic any_irq;
		logic port_async;
		logic two_wire_serial;
		logic rtc;
	} slpck_wake_s;

	////////////////////////////////////////////////////////////////////////
	// Widths and counts
	localparam int             SLPCK_CNT_W        = 16;
	localparam int             SLPCK_PSC_W        = 3;
	localparam int             SLPCK_DIV_W        = 8;
	localparam logic [15:0]    SLPCK_RC_START_CYC = 16'h0006;
	localparam logic [15:0]    SLPCK_ISR_MIN_CYC  = 16'h000D;
	localparam logic [15:0]    SLPCK_CERAMIC_CYC  = 16'h03E8;
	localparam logic [15:0]    SLPCK_QUARTZ_CYC   = 16'h3E80;
	localparam logic [7:0]     SLPCK_DIV_RST      = 8'h00;
	localparam logic [2:0]     SLPCK_PSC_RST      = 3'h0;
	localparam slpck_gate_s    SLPCK_GATE_ALL     = 7'h7F;

endpackage

// ### slpck_delay.sv
// Down-counting start-up and latency delay timer
`timescale 1ns/10ps
module slpck_delay
	import slpck_pkg::*;
(
	input  wire logic                   i_clock,
	input  wire logic                   i_srst,
	input  wire logic                   i_ce,
	input  wire logic                   i_load,
	input  wire logic [SLPCK_CNT_W-1:0] i_count,
	output logic                        o_busy,
	output logic                        o_done
);

	typedef struct packed {
		logic                   busy;
		logic [SLPCK_CNT_W-1:0] cnt;
	} slpck_dly_s;

	slpck_dly_s st_r;
	slpck_dly_s st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Load starts a run of i_count cycles; done marks the last of them
	always_comb begin
		st_nxt = st_r;
		if (i_load) begin
			st_nxt.busy = (i_count != '0);
			st_nxt.cnt  = i_count;
		end else if (st_r.busy) begin
			st_nxt.cnt  = st_r.cnt - 1'b1;
			st_nxt.busy = (st_r.cnt != 16'h0001);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			st_r <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_busy = st_r.busy;
	assign o_done = st_r.busy && (st_r.cnt == 16'h0001); // One-cycle pulse on the last busy cycle

endmodule // slpck_delay

// ### slpck_prescaler.sv
// Glitch-free clock prescaler producing a divided clock tick
`timescale 1ns/10ps
module slpck_prescaler
	import slpck_pkg::*;
(
	input  wire logic                   i_clock,
	input  wire logic                   i_srst,
	input  wire logic                   i_ce,
	input  wire logic [SLPCK_PSC_W-1:0] i_ratio,
	output logic                        o_tick
);

	typedef struct packed {
		logic [SLPCK_PSC_W-1:0] ratio;
		logic [SLPCK_DIV_W-1:0] cnt;
		logic                   tick;
	} slpck_psc_s;

	slpck_psc_s st_r;
	slpck_psc_s st_nxt;

	////////////////////////////////////////////////////////////////////////
	// A new ratio is taken only at a period boundary, so no period is
	// ever cut short; a tick is one cycle wide, never a runt
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt == '0) begin
			st_nxt.tick  = 1'b1;
			st_nxt.ratio = i_ratio;
			st_nxt.cnt   = SLPCK_DIV_W'((1 << i_ratio) - 1);
		end else begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			st_r <= '{ratio: SLPCK_PSC_RST, cnt: SLPCK_DIV_RST, tick: 1'b0};
		end else if (i_ce) begin
			st_r <= st_nxt;
		end
	end

	assign o_tick = st_r.tick;

endmodule // slpck_prescaler

// ### slpck_cpu_model.sv
// Far-side model: CPU sleep requests and wake event sources
`timescale 1ns/10ps
module slpck_cpu_model
	import slpck_pkg::*;
(
	input  wire logic  i_clock,
	output logic       o_sleep_en,
	output slpck_mode_e o_sleep_mode,
	output logic       o_sleep_instr,
	output slpck_wake_s o_wake
);
	////////////////////////////////////////////////////////////////////////
	// Released sources read low, so stale wake levels never linger
	initial begin
		o_sleep_en    = 1'b0;
		o_sleep_mode  = SLPCK_IDLE;
		o_sleep_instr = 1'b0;
		o_wake        = '0;
	end

	// Mode written while awake, then a one-cycle sleep instruction
	task automatic do_sleep(input slpck_mode_e m, input logic en);
		o_sleep_mode  = m;
		o_sleep_en    = en;
		@(negedge i_clock);
		o_sleep_instr = 1'b1;
		@(negedge i_clock);
		o_sleep_instr = 1'b0;
	endtask

	// Software may rewrite the mode at any time between entries
	task automatic set_mode(input slpck_mode_e m);
		o_sleep_mode = m;
	endtask

	// Event held across one sampling edge, then released
	task automatic wake(input slpck_wake_s w);
		o_wake = w;
		@(negedge i_clock);
		o_wake = '0;
	endtask
endmodule // slpck_cpu_model

// ### slpck_ctrl_bench.sv
// Self-checking bench for the sleep-mode clock controller
`timescale 1ns/10ps
module slpck_ctrl_bench
	import slpck_pkg::*;
;
	localparam logic [15:0] QZ = 16'h0014;
	logic                   i_clock;
	logic                   i_srst;
	logic                   i_ce;
	logic                   i_xtal_ceramic;
	logic                   i_batt_rtc;
	slpck_src_e             i_clk_src;
	logic [SLPCK_PSC_W-1:0] i_prescale;
	logic                   sleep_en;
	slpck_mode_e            sleep_mode;
	logic                   sleep_instr;
	slpck_wake_s            wake;
	slpck_gate_s            o_gate;
	logic                   o_cpu_tick;
	logic                   o_per_tick;
	logic                   o_asleep;
	logic                   o_cpu_run;
	logic                   o_isr_go;
	slpck_mode_e            o_mode;
	int                     miscompares;
	int                     cmp_count;
	logic [7:0]             lfsr;

	////////////////////////////////////////////////////////////////////////
	// Design and far-side model
	slpck_ctrl #(.P_QUARTZ_CYC(QZ)) u_dut (
		.i_clock(i_clock), .i_srst(i_srst), .i_ce(i_ce),
		.i_sleep_en(sleep_en), .i_sleep_mode(sleep_mode),
		.i_sleep_instr(sleep_instr), .i_wake(wake),
		.i_clk_src(i_clk_src), .i_xtal_ceramic(i_xtal_ceramic),
		.i_batt_rtc(i_batt_rtc), .i_prescale(i_prescale),
		.o_gate(o_gate), .o_cpu_tick(o_cpu_tick),
		.o_per_tick(o_per_tick), .o_asleep(o_asleep),
		.o_cpu_run(o_cpu_run), .o_isr_go(o_isr_go), .o_mode(o_mode));

	slpck_cpu_model u_cpu (
		.i_clock(i_clock), .o_sleep_en(sleep_en),
		.o_sleep_mode(sleep_mode), .o_sleep_instr(sleep_instr),
		.o_wake(wake));

	// 25 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end

	////////////////////////////////////////////////////////////////////////
	// Reference model: gating, wake permission and delays
	function automatic slpck_gate_s exp_gate(slpck_mode_e m, logic batt);
		slpck_gate_s g;
		case (m)
			SLPCK_IDLE:  g = 7'h3D;
			SLPCK_PSAVE: g = 7'h14;
			SLPCK_STBY:  g = 7'h08;
			SLPCK_ESTBY: g = 7'h1C;
			SLPCK_PDOWN: g = 7'h00;
			// Unlisted codes gate like idle
			default:     g = 7'h3D;
		endcase
		if (batt) begin
			g.rtc_clk = 1'b1;
			g.rtc_osc = 1'b1;
		end
		return g;
	endfunction

	function automatic bit permitted(slpck_mode_e m, slpck_wake_s w);
		if (w.port_async || w.two_wire_serial)
			return 1'b1;
		if (m == SLPCK_IDLE)
			return w.any_irq || w.rtc;
		if (m == SLPCK_PSAVE || m == SLPCK_ESTBY)
			return w.rtc;
		return 1'b0;
	endfunction

	// Only modes that stop the system oscillator pay its start-up
	function automatic int osc_cyc(slpck_mode_e m);
		if (m != SLPCK_PDOWN && m != SLPCK_PSAVE)
			return 0;
		if (i_clk_src != SLPCK_SRC_XTAL)
			return 6;
		return i_xtal_ceramic ? 1000 : int'(QZ);
	endfunction

	function automatic logic [7:0] lfsr_next(logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	task automatic chk(input logic [15:0] seen, exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// One sleep entry and wake, timed against the reference
	task automatic sleep_wake(input slpck_mode_e m, input slpck_wake_s w);
		int pt;
		int ct;
		int j;
		int first;
		int got;
		slpck_gate_s eg;
		eg = exp_gate(m, 1'b0);
		u_cpu.do_sleep(m, 1'b1);
		chk(16'(o_asleep), 16'h0001, "asleep");
		chk(16'(o_gate), 16'(exp_gate(m, i_batt_rtc)), "gate");
		u_cpu.set_mode(SLPCK_IDLE);
		pt = 0;
		ct = 0;
		// Ratio 0 ticks every cycle, so counts are exact
		repeat (4) begin
			@(negedge i_clock);
			pt += int'(o_per_tick === 1'b1);
			ct += int'(o_cpu_tick === 1'b1);
		end
		chk(16'(ct), 16'h0000, "cpu ticks asleep");
		chk(16'(pt), eg.per_clk ? 16'h0004 : 16'h0000, "per ticks");
		chk(16'(o_mode), 16'(m), "mode held");
		u_cpu.wake(w);
		if (!permitted(m, w)) begin
			repeat (2) @(negedge i_clock);
			chk(16'(o_asleep), 16'h0001, "not woken");
			w = '0;
			w.two_wire_serial = lfsr[0];
			w.port_async = ~lfsr[0];
			u_cpu.wake(w);
		end
		first = 0;
		got = 0;
		j = 1;
		while (got == 0 && j < 2000) begin
			if (o_cpu_run === 1'b1 && first == 0)
				first = j;
			if (o_isr_go === 1'b1)
				got = j;
			else begin
				@(negedge i_clock);
				j++;
			end
		end
		chk(16'(first), 16'(osc_cyc(m) + 1), "cpu resume");
		chk(16'(got), 16'(osc_cyc(m) + 14), "isr start");
		chk(16'(o_gate), 16'(SLPCK_GATE_ALL), "awake gate");
	endtask

	// Tick spacing after a ratio change, old period first
	task automatic psc_check(input logic [2:0] n);
		int gap;
		i_prescale = n;
		repeat (3) begin
			gap = 0;
			do begin
				@(negedge i_clock);
				gap++;
			end while (o_cpu_tick !== 1'b1 && gap < 300);
		end
		chk(16'(gap), 16'(1 << n), "tick gap");
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		miscompares = 0;
		cmp_count = 0;
		lfsr = 8'h46;
		i_srst = 1'b1;
		i_ce = 1'b1;
		i_clk_src = SLPCK_SRC_RC;
		i_xtal_ceramic = 1'b0;
		i_batt_rtc = 1'b0;
		i_prescale = 3'h0;
		repeat (3) @(negedge i_clock);
		chk(16'({o_gate, o_asleep, o_cpu_run, o_isr_go}),
		    16'h03FA, "reset");
		chk(16'(o_mode), 16'(SLPCK_IDLE), "reset mode");
		i_srst = 1'b0;
		// Sleep instruction without enable is ignored
		u_cpu.do_sleep(SLPCK_PDOWN, 1'b0);
		chk(16'(o_asleep), 16'h0000, "refused");
		// Frozen by clock enable: a full request must not enter sleep
		i_ce = 1'b0;
		u_cpu.do_sleep(SLPCK_PDOWN, 1'b1);
		chk(16'(o_asleep), 16'h0000, "frozen");
		i_ce = 1'b1;
		$display("Test refused entry done");
		// Every mode, random wake events
		for (int r = 0; r < 10; r++) begin
			lfsr = lfsr_next(lfsr);
			sleep_wake(slpck_mode_e'(r % 5), slpck_wake_s'(lfsr[3:0]));
		end
		$display("Test modes done");
		// Source dependent start-up
		sleep_wake(SLPCK_PSAVE, 4'h1);
		i_clk_src = SLPCK_SRC_EXT;
		sleep_wake(SLPCK_PSAVE, 4'h1);
		i_clk_src = SLPCK_SRC_XTAL;
		sleep_wake(SLPCK_PDOWN, 4'h4);
		i_xtal_ceramic = 1'b1;
		sleep_wake(SLPCK_PSAVE, 4'h1);
		i_clk_src = SLPCK_SRC_RC;
		$display("Test clock sources done");
		// Battery variant: RTC runs but still cannot wake
		i_batt_rtc = 1'b1;
		sleep_wake(SLPCK_PDOWN, 4'h1);
		sleep_wake(SLPCK_STBY, 4'h9);
		i_batt_rtc = 1'b0;
		// Unlisted code: idle gating, external wake only
		sleep_wake(slpck_mode_e'(3'h5), 4'h8);
		$display("Test battery variant done");
		// Large to small ratios back to back
		for (int n = 7; n >= 0; n--)
			psc_check(3'(n));
		$display("Test prescaler done");
		wrap_up();
	end

	// Hang guard, well beyond the expected run
	initial begin
		#(40 * 30000);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule // slpck_ctrl_bench
